//--- common/adcc_pkg.sv
// adcc_pkg: constants and carriers for the converter control and result logic.
// assumes one 50 MHz system clock; serial link and pins arrive asynchronously.
package adcc_pkg;
  // register select codes carried in the command byte
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_SETUP  = 4'h1;
  localparam logic [3:0] ADDR_PORT   = 4'h2;
  localparam logic [3:0] ADDR_GAIN   = 4'h3;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  // reset values
  localparam logic [7:0] SETUP_RST = 8'h02;
  localparam logic [7:0] PORT_RST  = 8'h0F;
  localparam logic [7:0] GAIN_RST  = 8'h1E;
  // command byte layout
  localparam int CMD_START_BIT = 7;
  localparam int CMD_CONV_BIT  = 6;
  localparam int CMD_ADDR_LSB  = 1;
  localparam int CMD_RD_BIT    = 0;
  // frame lengths in link clock edges
  localparam logic [5:0] CMD_BITS   = 6'h08;
  localparam logic [5:0] BYTE_END   = 6'h10;
  localparam logic [5:0] RESULT_END = 6'h20;
  // port control field positions
  localparam int PORT_DIR_LSB = 4;
  // calibration arithmetic: gain 1.0 is 2^22, so a coefficient reaches just under 4x
  localparam int GAIN_FRAC = 22;
  localparam logic [1:0] DISCARD_COUNT = 2'h3;
  // result coding limits, 20-bit result
  localparam logic signed [47:0] UNI_MAX = 48'sh0000_000F_FFFF;
  localparam logic signed [47:0] UNI_MIN = 48'sh0000_0000_0000;
  localparam logic signed [47:0] BIP_MAX = 48'sh0000_0007_FFFF;
  localparam logic signed [47:0] BIP_MIN = 48'shFFFF_FFF8_0000;
  localparam logic [19:0] SIGN_FLIP = 20'h80000;

  typedef struct packed {
    logic mains_rate_select;
    logic unipolar;
    logic external_timebase_select;
    logic reference_buffer_enable;
    logic input_buffer_enable;
    logic offset_binary;
    logic single_shot_select;
    logic unused;
  } adcc_setup_type;

  typedef struct packed {
    logic [2:0] digital_gain;
    logic       system_gain_bypass;
    logic       system_offset_bypass;
    logic       selfcal_gain_bypass;
    logic       selfcal_offset_bypass;
    logic       reserved;
  } adcc_gain_type;

  typedef struct packed {
    logic signed [23:0] selfcal_offset;
    logic        [23:0] selfcal_gain;
    logic signed [23:0] system_offset;
    logic        [23:0] system_gain;
  } adcc_cal_type;

  typedef enum logic [1:0] {
    ST_DOWN    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_STORE   = 2'b11
  } adcc_state_type;
endpackage : adcc_pkg

//--- hw/adcc_core.sv
// adcc_core: setup, port and gain registers, conversion sequencing, calibration
// datapath, result register and the four-wire serial slave that reaches them.
// assumes modulator samples arrive on clk_sys; serial pins and gpio are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - mains_rate_select 1 centres rates for 50Hz mains, 0 for 60Hz.
// R2 - polarity bit 1 selects unipolar input range, 0 selects bipolar.
// R3 - external_timebase_select 1 picks external clock, 0 the internal oscillator.
// R4 - reference_buffer_enable 1 powers reference buffers; 0 powers down and bypasses.
// R5 - input_buffer_enable 1 powers signal buffers; 0 powers down and bypasses.
// R6 - bipolar codes two's complement at 0, offset binary at 1; unipolar straight.
// R7 - single_shot_select 1 does one conversion without latency, then powers down.
// R8 - single_shot_select 0 converts continuously; first three results are invalid.
// R9 - end of each conversion shows as 0 to 1 on ready_data_out.
// R10 - host keeps select low and times result reads from ready rising edge.
// R11 - direction 0 makes pin an input read back; 1 drives level bit.
// R12 - three-bit digital_gain decodes as power of two, 1 up to 128.
// R13 - digital gain applies after full calibration, shrinking usable input range.
// R14 - system_gain_bypass 1 omits system gain coefficient, 0 applies it.
// R15 - system_offset_bypass 1 omits system offset coefficient, 0 applies it.
// R16 - selfcal_gain_bypass 1 omits self-calibration gain, 0 applies it.
// R17 - selfcal_offset_bypass 1 omits self-calibration offset, 0 applies it.
// R18 - result register is read-only; writes change nothing.
// R19 - 24-bit result shifts out MSB first: 20 result bits, four zeros.
// R20 - unipolar codes zero, half and full reference as 00000, 80000, FFFFF.
// R21 - two's complement codes -FS, zero, +FS as 80000, 00000, 7FFFF.
// R22 - out-of-range inputs clamp to the coding's minimum or maximum code.
// R23 - clipping at maximum sets overrange, at minimum underrange; else both clear.
// R24 - order: selfcal offset, selfcal gain, system offset, then system gain.
// R25 - reset loads gain code zero and sets all four bypass bits.
module adcc_core
  import adcc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // serial link
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              din,
  output var  logic              ready_data_out,
  // general purpose pins
  input  wire logic [3:0]        gpio_in,
  output var  logic [3:0]        gpio_out,
  output var  logic [3:0]        gpio_oe_n,
  // modulator sample stream
  input  wire logic              sample_valid,
  input  wire logic signed [23:0] sample_data,
  output var  logic              sample_ready,
  // calibration coefficients
  input  wire adcc_cal_type      cal_coeff,
  // analog and clock controls, range flags
  output var  logic              mains_rate_select,
  output var  logic              external_timebase_select,
  output var  logic              reference_buffer_enable,
  output var  logic              input_buffer_enable,
  output var  logic              modulator_power,
  output var  logic              overrange,
  output var  logic              underrange
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0]           sclk_sync_q;
  logic [1:0]           cs_sync_q;
  logic [1:0]           din_sync_q;
  logic [3:0]           gpio_s1_q;
  logic [3:0]           gpio_s2_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 link_active;
  logic [5:0]           bit_cnt_q;
  logic [7:0]           cmd_q;
  logic [7:0]           wdata_q;
  logic [7:0]           cmd_next;
  logic [23:0]          shift_out_q;
  logic                 reading_q;
  logic                 result_read_q;
  logic [5:0]           frame_end_q;
  adcc_setup_type       setup_q;
  logic [7:0]           port_q;
  adcc_gain_type        gain_q;
  logic [23:0]          result_q;
  logic [19:0]          stage_q;
  logic                 stage_ovr_q;
  logic                 stage_und_q;
  logic                 fresh_q;
  logic                 armed_q;
  logic                 conv_cmd;
  logic [1:0]           discard_q;
  adcc_state_type       state_q;
  adcc_state_type       state_d;
  logic                 pop;
  logic signed [23:0]   fifo_mem_q [2];
  logic                 wr_ptr_q;
  logic                 rd_ptr_q;
  logic [1:0]           fifo_cnt_q;
  logic                 push;
  logic signed [47:0]   calc;
  logic [19:0]          code;
  logic                 clip_hi;
  logic                 clip_lo;

  // scale by an unsigned fixed-point coefficient, 1.0 at 2^GAIN_FRAC
  function automatic logic signed [47:0] gain_mul(input logic signed [47:0] x,
                                                  input logic [23:0] g);
    logic signed [72:0] p;
    p = x * $signed({1'b0, g});
    return p[GAIN_FRAC+47:GAIN_FRAC];
  endfunction : gain_mul

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: link clock is sampled, never used as a clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_sync_q <= 3'h0;
      cs_sync_q   <= 2'h3;
      din_sync_q  <= 2'h0;
      gpio_s1_q   <= 4'h0;
      gpio_s2_q   <= 4'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      cs_sync_q   <= {cs_sync_q[0], cs_n};
      din_sync_q  <= {din_sync_q[0], din};
      gpio_s1_q   <= gpio_in;
      gpio_s2_q   <= gpio_s1_q;
    end
  end

  // edges from the second and third stage only
  assign sclk_rise   = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall   = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign link_active = ~cs_sync_q[1];
  assign cmd_next    = {cmd_q[6:0], din_sync_q[1]};

  ////////////////////////////////////////////////////////////////////////////
  // serial frame: command byte, then one write byte or the read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bit_cnt_q     <= 6'h00;
      cmd_q         <= 8'h00;
      wdata_q       <= 8'h00;
      shift_out_q   <= 24'h000000;
      reading_q     <= 1'b0;
      result_read_q <= 1'b0;
      frame_end_q   <= CMD_BITS;
    end else if (!link_active) begin
      bit_cnt_q     <= 6'h00;
      reading_q     <= 1'b0;
      result_read_q <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
      if (bit_cnt_q < CMD_BITS) begin
        cmd_q <= cmd_next;
      end else begin
        wdata_q <= {wdata_q[6:0], din_sync_q[1]};
      end
      if (bit_cnt_q == CMD_BITS - 6'h01) begin
        frame_end_q <= CMD_BITS;
        if (cmd_next[CMD_START_BIT] && !cmd_next[CMD_CONV_BIT]) begin
          frame_end_q <= BYTE_END;
          if (cmd_next[CMD_RD_BIT]) begin
            reading_q <= 1'b1;
            case (cmd_next[CMD_ADDR_LSB+3:CMD_ADDR_LSB])
              ADDR_STATUS: begin
                shift_out_q <= {4'h0, stage_ovr_q, stage_und_q, ~(state_q == ST_DOWN),
                                fresh_q, 16'h0000};
              end
              ADDR_SETUP: begin
                shift_out_q <= {setup_q, 16'h0000};
              end
              ADDR_PORT: begin
                // input pins read their level, outputs read the written bit; see R11
                shift_out_q <= {port_q[7:4],
                                (port_q[7:4] & port_q[3:0]) | (~port_q[7:4] & gpio_s2_q),
                                16'h0000};
              end
              ADDR_GAIN: begin
                shift_out_q <= {gain_q, 16'h0000};
              end
              ADDR_RESULT: begin
                shift_out_q   <= result_q;                  // MSB first; see R19
                result_read_q <= 1'b1;
                frame_end_q   <= RESULT_END;
              end
              default: begin
                shift_out_q <= 24'h000000;
              end
            endcase
          end
        end
      end
      // frame complete: count restarts so select may stay low; a lone command
      // byte ends at its eighth bit whatever length the frame before it had
      if ((bit_cnt_q == CMD_BITS - 6'h01)
          ? !(cmd_next[CMD_START_BIT] && !cmd_next[CMD_CONV_BIT])
          : (bit_cnt_q + 6'h01 == frame_end_q && bit_cnt_q >= CMD_BITS)) begin
        bit_cnt_q     <= 6'h00;
        reading_q     <= 1'b0;
        result_read_q <= 1'b0;
      end
    end else if (sclk_fall && reading_q && bit_cnt_q > CMD_BITS) begin
      shift_out_q <= {shift_out_q[22:0], 1'b0};
    end
  end

  // convert command: start bit with conversion flag, no data phase
  assign conv_cmd = link_active && sclk_rise && bit_cnt_q == CMD_BITS - 6'h01
                    && cmd_next[CMD_START_BIT] && cmd_next[CMD_CONV_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // register writes; result and status addresses have no write path, see R18
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      setup_q <= adcc_setup_type'(SETUP_RST);
      port_q  <= PORT_RST;
      gain_q  <= adcc_gain_type'(GAIN_RST);                  // see R25
    end else if (link_active && sclk_rise && bit_cnt_q == BYTE_END - 6'h01
                 && cmd_q[CMD_START_BIT] && !cmd_q[CMD_CONV_BIT] && !cmd_q[CMD_RD_BIT]) begin
      case (cmd_q[CMD_ADDR_LSB+3:CMD_ADDR_LSB])
        ADDR_SETUP: setup_q <= adcc_setup_type'({wdata_q[6:0], din_sync_q[1]});
        ADDR_PORT:  port_q  <= {wdata_q[6:0], din_sync_q[1]};
        ADDR_GAIN:  gain_q  <= adcc_gain_type'({wdata_q[6:0], din_sync_q[1]});
        default:    setup_q <= setup_q;
      endcase
    end
  end

  // analog and clock steering straight from setup
  assign mains_rate_select        = setup_q.mains_rate_select;        // see R1
  assign external_timebase_select = setup_q.external_timebase_select; // see R3
  assign reference_buffer_enable  = setup_q.reference_buffer_enable;  // see R4
  assign input_buffer_enable      = setup_q.input_buffer_enable;      // see R5
  // pins driven only where direction is 1, oe low means driving; see R11
  assign gpio_out  = port_q[3:0];
  assign gpio_oe_n = ~port_q[7:PORT_DIR_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // two-entry sample buffer; a full buffer stalls the modulator stream
  assign sample_ready = fifo_cnt_q != 2'h2;
  assign push         = sample_valid && sample_ready;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      fifo_cnt_q <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem_q[wr_ptr_q] <= sample_data;
        wr_ptr_q             <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration, gain and coding of the buffer head
  always_comb begin
    calc = 48'(fifo_mem_q[rd_ptr_q]);
    // fixed order of corrections; see R24
    if (!gain_q.selfcal_offset_bypass) calc = calc - 48'(cal_coeff.selfcal_offset); // see R17
    if (!gain_q.selfcal_gain_bypass)   calc = gain_mul(calc, cal_coeff.selfcal_gain); // see R16
    if (!gain_q.system_offset_bypass)  calc = calc - 48'(cal_coeff.system_offset);  // see R15
    if (!gain_q.system_gain_bypass)    calc = gain_mul(calc, cal_coeff.system_gain); // see R14
    // unipolar spans the full code range, hence the 2x scale; see R2
    if (setup_q.unipolar) calc = calc <<< 1;
    // power-of-two gain after calibration narrows the input range; see R12, R13
    calc = calc <<< gain_q.digital_gain;
    // clamp to the coding's limits; see R22, R23
    clip_hi = setup_q.unipolar ? (calc > UNI_MAX) : (calc > BIP_MAX);
    clip_lo = setup_q.unipolar ? (calc < UNI_MIN) : (calc < BIP_MIN);
    if (clip_hi) calc = setup_q.unipolar ? UNI_MAX : BIP_MAX;
    if (clip_lo) calc = setup_q.unipolar ? UNI_MIN : BIP_MIN;
    // straight binary, two's complement or offset binary; see R6, R20, R21
    code = calc[19:0];
    if (!setup_q.unipolar && setup_q.offset_binary) code = code ^ SIGN_FLIP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  // a result read in progress holds off the update, avoiding a torn read
  assign pop = state_q == ST_CONVERT && fifo_cnt_q != 2'h0 && !result_read_q
               && (!setup_q.single_shot_select || armed_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_DOWN: begin
        if (!setup_q.single_shot_select || armed_q) state_d = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (pop) state_d = ST_STORE;
        else if (setup_q.single_shot_select && !armed_q) state_d = ST_DOWN;
      end
      ST_STORE: begin
        // one conversion then leakage-only state; see R7
        state_d = setup_q.single_shot_select ? ST_DOWN : ST_CONVERT;
      end
      default: state_d = ST_DOWN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) state_q <= ST_DOWN;
    else       state_q <= state_d;
  end

  assign modulator_power = state_q != ST_DOWN;

  // single-shot request; a new command in the pop cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (reset)         armed_q <= 1'b0;
    else if (conv_cmd) armed_q <= setup_q.single_shot_select;
    else if (pop)      armed_q <= 1'b0;
  end

  // filter settling: first three continuous results are dropped; see R8
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      discard_q <= 2'h0;
    end else if (state_q == ST_DOWN && state_d == ST_CONVERT) begin
      discard_q <= setup_q.single_shot_select ? 2'h0 : DISCARD_COUNT;
    end else if (state_q == ST_STORE && discard_q != 2'h0) begin
      discard_q <= discard_q - 2'h1;
    end
  end

  // stage then commit; ready line drops at pop and rises on commit, see R9
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage_q     <= 20'h00000;
      stage_ovr_q <= 1'b0;
      stage_und_q <= 1'b0;
      result_q    <= 24'h000000;
      fresh_q     <= 1'b0;
    end else begin
      if (pop) begin
        stage_q     <= code;
        stage_ovr_q <= clip_hi;
        stage_und_q <= clip_lo;
        fresh_q     <= 1'b0;
      end
      if (state_q == ST_STORE && discard_q == 2'h0) begin
        result_q <= {stage_q, 4'h0};                         // see R19
        fresh_q  <= 1'b1;
      end
    end
  end

  assign overrange  = stage_ovr_q;
  assign underrange = stage_und_q;

  // shared line: read data while reading, else the ready level; see R9, R10
  always_ff @(posedge clk_sys) begin
    if (reset) ready_data_out <= 1'b0;
    else       ready_data_out <= reading_q ? shift_out_q[23] : fresh_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_result_read_only: assert property (@(posedge clk_sys) disable iff (reset) // see R18
    state_q != ST_STORE |=> $stable(result_q))
    else $error("result changed outside a commit");

  a_ready_rises_end: assert property (@(posedge clk_sys) disable iff (reset) // see R9
    state_q == ST_STORE && discard_q == 2'h0 |-> !fresh_q ##1 fresh_q ##1 ready_data_out
      || reading_q)
    else $error("end of conversion not shown as rising ready");

  a_discard_no_ready: assert property (@(posedge clk_sys) disable iff (reset) // see R8
    state_q == ST_STORE && discard_q != 2'h0 |=> !fresh_q && $stable(result_q))
    else $error("settling result was published");

  a_single_powers_down: assert property (@(posedge clk_sys) disable iff (reset) // see R7
    state_q == ST_STORE && setup_q.single_shot_select |=> !modulator_power)
    else $error("single shot did not power down");

  a_clip_high_code: assert property (@(posedge clk_sys) disable iff (reset) // see R22
    pop && clip_hi && setup_q.unipolar |=> stage_q == 20'hFFFFF && overrange && !underrange)
    else $error("overrange result not clamped to maximum");

  a_clip_low_code: assert property (@(posedge clk_sys) disable iff (reset) // see R21
    pop && clip_lo && !setup_q.unipolar && !setup_q.offset_binary
      |=> stage_q == 20'h80000 && underrange)
    else $error("underrange result not clamped to minimum");

  a_read_blocks_update: assert property (@(posedge clk_sys) disable iff (reset) // see R10
    result_read_q |=> state_q != ST_STORE && fifo_cnt_q >= $past(fifo_cnt_q))
    else $error("result updated during a result read");

  a_buffer_stalls: assert property (@(posedge clk_sys) disable iff (reset)
    fifo_cnt_q == 2'h2 && !pop |=> fifo_cnt_q == 2'h2 && !sample_ready)
    else $error("full buffer accepted or lost a sample");

  a_reset_bypass: assert property (@(posedge clk_sys) // see R25
    $fell(reset) |-> gain_q == adcc_gain_type'(GAIN_RST) && setup_q.single_shot_select)
    else $error("control registers not at reset values");

endmodule : adcc_core

`default_nettype wire

//--- sim/adcc_host_model.sv
// adcc_host_model: host side of the four-wire serial link.
// assumes clk_sys from the bench; sclk is made here, 160 ns, idle low.
`timescale 1ns/1ps
`default_nettype none
module adcc_host_model (
  input  wire logic clk_sys,
  input  wire logic ready_data_out,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // one frame msb first, each bit 4 clk low then 4 clk high
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    cs_n <= 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      din <= tx[i];
      repeat (4) @(negedge clk_sys);
      // taken just before the rise: the device shifts about four clk after a fall,
      // and the last rise of a frame hands the line back to the ready level
      rx = {rx[30:0], ready_data_out};
      sclk <= 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    cs_n <= 1'b1;
    din  <= ~din; // released line shows no stale bit
    repeat (8) @(negedge clk_sys);
  endtask : xfer
  // register write: start bit, address, write flag, then one byte
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] rx;
    xfer(16, {16'h0000, 2'b10, 1'b0, a, 1'b0, d}, rx);
  endtask : wr
  // register read of n bits after the command byte
  task automatic rd(input logic [3:0] a, input int n, output logic [31:0] d);
    xfer(8 + n, 32'({2'b10, 1'b0, a, 1'b1}) << n, d);
  endtask : rd
  // conversion command alone, eight bits
  task automatic conv();
    logic [31:0] rx;
    xfer(8, 32'h000000C0, rx);
  endtask : conv
endmodule : adcc_host_model
`default_nettype wire

//--- sim/tb_adcc_core.sv
// tb_adcc_core: self-checking bench for the converter control block.
// assumes adcc_host_model on the serial pins; stream and gpio are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_core
  import adcc_pkg::*;
();
  localparam logic [19:0] CODES [3][3] = '{'{20'h00000, 20'hFFFFF, 20'h00000},
    '{20'h00000, 20'h7FFFF, 20'h80000}, '{20'h80000, 20'hFFFFF, 20'h00000}};
  logic               clk_sys, reset, cs_n, sclk, din, ready_data_out;
  logic               sample_valid, sample_ready, cnt_en, prev_rdy;
  logic               mrs, ets, rbe, ibe, mpw, ovr, und;
  logic [3:0]         gpio_in, gpio_out, gpio_oe_n, r;
  logic [7:0]         s;
  logic [19:0]        last;
  logic [31:0]        v;
  logic signed [23:0] sample_data;
  adcc_cal_type       cal_coeff;
  int                 failures = 0, checks_done = 0, rises = 0, r0;
  adcc_core dut_u (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
    .ready_data_out(ready_data_out), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_ready(sample_ready), .cal_coeff(cal_coeff), .mains_rate_select(mrs),
    .external_timebase_select(ets), .reference_buffer_enable(rbe),
    .input_buffer_enable(ibe), .modulator_power(mpw), .overrange(ovr), .underrange(und));
  adcc_host_model host_u (.clk_sys(clk_sys), .ready_data_out(ready_data_out), .cs_n(cs_n),
    .sclk(sclk), .din(din));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // end-of-conversion edges; reads are masked since data bits also rise
  always @(negedge clk_sys) begin
    prev_rdy <= ready_data_out;
    if (cnt_en && ready_data_out === 1'b1 && prev_rdy === 1'b0) rises <= rises + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic rdr(input logic [3:0] a, input int n);
    cnt_en <= 1'b0;
    host_u.rd(a, n, v);
    cnt_en <= 1'b1;
  endtask : rdr
  // one word into the stream; valid held until a cycle with room
  task automatic push(input logic [23:0] d);
    sample_valid <= 1'b1;
    sample_data  <= d;
    for (int i = 0; i < 100 && sample_ready !== 1'b1; i++) @(negedge clk_sys);
    if (sample_ready !== 1'b1) begin
      failures++;
      summarize();
    end
    @(negedge clk_sys);
    sample_valid <= 1'b0;
    sample_data  <= ~d;
    @(negedge clk_sys);
  endtask : push
  task automatic wait_rise(input int base);
    for (int i = 0; i < 500 && rises == base; i++) @(negedge clk_sys);
    if (rises == base) begin
      failures++;
      summarize();
    end
  endtask : wait_rise
  task automatic convert();
    r0 = rises;
    host_u.conv();
    wait_rise(r0);
  endtask : convert
  ////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    sample_valid = 1'b0;
    sample_data = '0;
    cnt_en = 1'b1;
    gpio_in = 4'h5;
    cal_coeff = '0;
    void'($urandom(32'hDFB1));
    repeat (2) @(negedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check({gpio_oe_n, gpio_out, mrs, ets, rbe, ibe, mpw, ovr, und, sample_ready}, 16'hFF01);
    rdr(ADDR_SETUP, 8);
    check(v[7:0], SETUP_RST);
    rdr(ADDR_GAIN, 8);
    check(v[7:0], GAIN_RST);
    // port and gain registers, first pass reads the port reset value
    for (int i = 0; i < 5; i++) begin
      s = (i == 0) ? PORT_RST : 8'($urandom);
      gpio_in <= 4'($urandom);
      if (i > 0) host_u.wr(ADDR_PORT, s);
      rdr(ADDR_PORT, 8);
      check({gpio_oe_n, gpio_out}, {~s[7:4], s[3:0]});
      check(v[7:0], {s[7:4], s[7:4] & s[3:0] | ~s[7:4] & gpio_in});
      s = 8'($urandom) & 8'hFE;
      host_u.wr(ADDR_GAIN, s);
      rdr(ADDR_GAIN, 8);
      check(v[7:0], s);
    end
    cal_coeff <= '{24'($urandom_range(0, 4095)), 24'h400000,
                   24'($urandom_range(0, 4095)), 24'h400000};
    // every coding against zero, clip high, clip low and offset-cancelled input
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        r = 4'($urandom);
        s = {r[3], m == 0, r[2:0], m == 2 || (m == 0 && k[0]), 2'b10};
        host_u.wr(ADDR_SETUP, s);
        host_u.wr(ADDR_GAIN, (k == 3) ? 8'h00 : 8'hFE);
        push((k == 1) ? 24'h7FFFFF : (k == 2) ? 24'h800000 : (k == 3) ?
             cal_coeff.selfcal_offset + cal_coeff.system_offset : 24'h000000);
        convert();
        rdr(ADDR_RESULT, 24);
        last = CODES[m][k % 3];
        check(v[23:0], {last, 4'h0});
        check({ovr, und}, {k == 1, k == 2});
        check({mrs, ets, rbe, ibe, mpw}, {r, 1'b0});
      end
    end
    host_u.wr(ADDR_RESULT, 8'($urandom));
    rdr(ADDR_RESULT, 24);
    check(v[23:0], {last, 4'h0});
    // powered down: two words wait, then both drain on command
    push(24'h000000);
    push(24'h000000);
    check(sample_ready, 1'b0);
    convert();
    convert();
    check(sample_ready, 1'b1);
    // continuous: three results dropped, the fourth signalled at a random gain
    r = 4'($urandom_range(0, 7));
    last = 20'($urandom_range(0, 4095));
    host_u.wr(ADDR_GAIN, {r[2:0], 5'h1E});
    host_u.wr(ADDR_SETUP, 8'h00);
    r0 = rises;
    for (int i = 0; i < 3; i++) push(24'h000000);
    repeat (40) @(negedge clk_sys);
    check(rises - r0, 0);
    check(mpw, 1'b1);
    push({4'h0, last});
    wait_rise(r0);
    rdr(ADDR_RESULT, 24);
    check(v[23:0], {last << r[2:0], 4'h0});
    summarize();
  end
endmodule : tb_adcc_core
`default_nettype wire
